/* hdl/pllcs_pkg.sv */
// package: register map, field layout and timing constants for the pll clock select block
package pllcs_pkg;
   // ****************
   // register offsets
   // ****************
   localparam logic [3:0] ADDR_PLL_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_SYS_CLOCK_CONTROL = 4'h4;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
   // ****************
   // field positions
   // ****************
   localparam int POS_PLL_ENABLE = 0;
   localparam int POS_PLL_STABLE = 1;
   localparam int POS_PLL_OUT_LO = 2;
   localparam int POS_PLL_INPUT = 5;
   localparam int POS_FAST_SRC = 0;
   localparam int POS_SLOW_SRC = 1;
   localparam int POS_SYS_SEL_LO = 2;
   // ****************
   // reset values
   // ****************
   localparam logic       RST_PLL_ENABLE = 1'b1;
   localparam logic [2:0] RST_PLL_OUTPUT = 3'h0;
   localparam logic       RST_PLL_INPUT = 1'b0;
   localparam logic [2:0] RST_SYS_SELECT = 3'h0;
   localparam logic       RST_FAST_SRC = 1'b0;
   localparam logic       RST_SLOW_SRC = 1'b0;
   localparam logic [1:0] RST_IRQ_MASK = 2'h0;
   // ****************
   // timing
   // ****************
   localparam int CLK_PERIOD_NS = 5;
   localparam int PLL_LOCK_TIME_NS = 100000;
   localparam int PLL_LOCK_CYCLES = (PLL_LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ****************
   // encodings
   // ****************
   typedef enum logic [1:0] {PLLCS_PLL_6M, PLLCS_PLL_12M, PLLCS_PLL_16M, PLLCS_PLL_NONE} pllcs_pll_freq_e;
   typedef enum {PLLCS_LOCK_OFF, PLLCS_LOCK_WAIT, PLLCS_LOCK_DONE} pllcs_lock_e;
   typedef struct packed {
      logic       fastSel;     // 1: ext_fast_crystal
      logic       slowSel;     // 1: ext_slow_crystal
      logic [2:0] sysSel;
   } pllcs_clk_ctl_s;
   typedef struct packed {
      logic       pllEnable;
      logic [2:0] pllOutSel;
      logic       pllInSel;    // 1: 6MHz crystal
   } pllcs_pll_ctl_s;
endpackage : pllcs_pkg

/* hdl/pllcs_top.sv */
// module: pll clock select control, pll lock tracking and source selection
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
module pllcs_top #(
   parameter int LOCK_CYCLES = pllcs_pkg::PLL_LOCK_CYCLES
) (
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic        clkEn,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             irq,
   output logic             usbClkOn,
   output logic             pllSysClkOn,
   output logic [1:0]       pllSysFreq,
   output logic             pllPreDivide,
   output logic             fastUsesCrystal,
   output logic             slowUsesCrystal,
   output logic [2:0]       sysClkSelect,
   output logic             wdtSlowCrystal,
   output logic             timeBaseFastCrystal,
   output logic             timeBaseSlowCrystal,
   output logic             pllStable
);
   // ****************
   // registers
   // ****************
   pllcs_pkg::pllcs_pll_ctl_s pllCtl;
   pllcs_pkg::pllcs_clk_ctl_s clkCtl;
   pllcs_pkg::pllcs_lock_e    lockState;
   logic [31:0]               lockCount;
   logic [1:0]                irqStatus;
   logic [1:0]                irqMask;
   logic                      stableD;

   // ****************
   // bus decode
   // ****************
   wire busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wrReq = busReq && wb_we_i && wb_sel_i[0];
   wire hitPllCtl = wb_adr_i == pllcs_pkg::ADDR_PLL_CONTROL;
   wire hitClkCtl = wb_adr_i == pllcs_pkg::ADDR_SYS_CLOCK_CONTROL;
   wire hitStat = wb_adr_i == pllcs_pkg::ADDR_IRQ_STATUS;
   wire hitMask = wb_adr_i == pllcs_pkg::ADDR_IRQ_MASK;
   wire rdStat = busReq && !wb_we_i && hitStat;
   wire [7:0] wrByte = wb_dat_i[7:0];
   // bit 7 reserved held at zero, bit 6 unimplemented
   wire [7:0] pllCtlRead = {2'h0, pllCtl.pllInSel, pllCtl.pllOutSel, pllStable, pllCtl.pllEnable};
   wire [7:0] clkCtlRead = {3'h0, clkCtl.sysSel, clkCtl.slowSel, clkCtl.fastSel};
   wire [7:0] readByte = hitPllCtl ? pllCtlRead :
                         hitClkCtl ? clkCtlRead :
                         hitStat ? {6'h00, irqStatus} :
                         hitMask ? {6'h00, irqMask} : 8'h00;

   // ****************
   // pll lock tracking
   // ****************
   // lock time is modelled, not measured: no analog lock detect here
   wire lockDone = lockCount >= 32'(LOCK_CYCLES - 1);
   wire pllReprog = wrReq && hitPllCtl &&
                    (wrByte[pllcs_pkg::POS_PLL_INPUT] != pllCtl.pllInSel);
   wire fastSrcChange = wrReq && hitClkCtl && (wrByte[pllcs_pkg::POS_FAST_SRC] != clkCtl.fastSel);
   assign pllStable = lockState == pllcs_pkg::PLLCS_LOCK_DONE;
   wire lockEvent = pllStable && !stableD;
   wire lossEvent = !pllStable && stableD;

   // ****************
   // clock selection outputs
   // ****************
   wire [2:0] outSel = pllCtl.pllOutSel;
   wire       pllForSys = pllCtl.pllEnable && outSel[2];
   always_comb begin
      pllSysFreq = 2'(pllcs_pkg::PLLCS_PLL_NONE);
      unique case (outSel[1:0])
         2'h0: pllSysFreq = 2'(pllcs_pkg::PLLCS_PLL_6M);
         2'h1: pllSysFreq = 2'(pllcs_pkg::PLLCS_PLL_12M);
         2'h2: pllSysFreq = 2'(pllcs_pkg::PLLCS_PLL_16M);
         2'h3: pllSysFreq = 2'(pllcs_pkg::PLLCS_PLL_NONE);
      endcase
   end
   // reserved code 111 never drives the system clock from the pll
   assign pllSysClkOn = pllForSys && (outSel[1:0] != 2'h3) && pllStable;
   assign usbClkOn = pllCtl.pllEnable && pllStable;
   assign pllPreDivide = !clkCtl.fastSel || !pllCtl.pllInSel;
   assign fastUsesCrystal = clkCtl.fastSel;
   assign slowUsesCrystal = clkCtl.slowSel;
   assign sysClkSelect = clkCtl.sysSel;
   assign wdtSlowCrystal = clkCtl.slowSel;
   assign timeBaseFastCrystal = clkCtl.fastSel;
   assign timeBaseSlowCrystal = clkCtl.slowSel;
   assign irq = |(irqStatus & irqMask);

   // ****************
   // register writes
   // ****************
   always_ff @(posedge mclk) begin
      if (reset) begin
         pllCtl.pllEnable <= pllcs_pkg::RST_PLL_ENABLE;
         pllCtl.pllOutSel <= pllcs_pkg::RST_PLL_OUTPUT;
         pllCtl.pllInSel <= pllcs_pkg::RST_PLL_INPUT;
      end else if (clkEn && wrReq && hitPllCtl) begin
         pllCtl.pllEnable <= wrByte[pllcs_pkg::POS_PLL_ENABLE];
         pllCtl.pllOutSel <= wrByte[pllcs_pkg::POS_PLL_OUT_LO +: 3];
         pllCtl.pllInSel <= wrByte[pllcs_pkg::POS_PLL_INPUT];
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         clkCtl.fastSel <= pllcs_pkg::RST_FAST_SRC;
         clkCtl.slowSel <= pllcs_pkg::RST_SLOW_SRC;
         clkCtl.sysSel <= pllcs_pkg::RST_SYS_SELECT;
      end else if (clkEn && wrReq && hitClkCtl) begin
         clkCtl.fastSel <= wrByte[pllcs_pkg::POS_FAST_SRC];
         clkCtl.slowSel <= wrByte[pllcs_pkg::POS_SLOW_SRC];
         clkCtl.sysSel <= wrByte[pllcs_pkg::POS_SYS_SEL_LO +: 3];
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         irqMask <= pllcs_pkg::RST_IRQ_MASK;
      end else if (clkEn && wrReq && hitMask) begin
         irqMask <= wrByte[1:0];
      end
   end

   // ****************
   // lock state machine
   // ****************
   always_ff @(posedge mclk) begin
      if (reset) begin
         lockState <= pllcs_pkg::PLLCS_LOCK_WAIT;
         lockCount <= 32'h0000_0000;
      end else if (clkEn) begin
         unique case (lockState)
            pllcs_pkg::PLLCS_LOCK_OFF: begin
               lockCount <= 32'h0000_0000;
               if (pllCtl.pllEnable) begin
                  lockState <= pllcs_pkg::PLLCS_LOCK_WAIT;
               end
            end
            pllcs_pkg::PLLCS_LOCK_WAIT: begin
               if (!pllCtl.pllEnable) begin
                  lockState <= pllcs_pkg::PLLCS_LOCK_OFF;
               end else if (pllReprog || fastSrcChange) begin
                  lockCount <= 32'h0000_0000;
               end else if (lockDone) begin
                  lockState <= pllcs_pkg::PLLCS_LOCK_DONE;
               end else begin
                  lockCount <= lockCount + 32'h0000_0001;
               end
            end
            pllcs_pkg::PLLCS_LOCK_DONE: begin
               lockCount <= 32'h0000_0000;
               if (!pllCtl.pllEnable) begin
                  lockState <= pllcs_pkg::PLLCS_LOCK_OFF;
               end else if (pllReprog || fastSrcChange) begin
                  lockState <= pllcs_pkg::PLLCS_LOCK_WAIT;
               end
            end
         endcase
      end
   end

   // ****************
   // interrupt status and bus answer
   // ****************
   // set wins over the clear on read
   always_ff @(posedge mclk) begin
      if (reset) begin
         stableD <= 1'b0;
         irqStatus <= 2'h0;
      end else if (clkEn) begin
         stableD <= pllStable;
         irqStatus <= (rdStat ? 2'h0 : irqStatus) | {lossEvent, lockEvent};
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (clkEn) begin
         wb_ack_o <= busReq;
         wb_dat_o <= (busReq && !wb_we_i) ? {24'h00_0000, readByte} : 32'h0000_0000;
      end
   end
endmodule : pllcs_top

/* verif/pllcs_props.sv */
// checker: bus timing and clock select relations of pllcs_top
`timescale 1ns/1ps
module pllcs_props #(
   parameter int LOCK_CYCLES = pllcs_pkg::PLL_LOCK_CYCLES
) (
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic        clkEn,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        usbClkOn,
   input wire logic        pllSysClkOn,
   input wire logic        pllPreDivide,
   input wire logic        fastUsesCrystal,
   input wire logic        slowUsesCrystal,
   input wire logic        wdtSlowCrystal,
   input wire logic        timeBaseFastCrystal,
   input wire logic        timeBaseSlowCrystal,
   input wire logic        pllStable
);
   localparam int LOCK_MAX = LOCK_CYCLES + 2;
   // ****************
   // lock wait counter
   // ****************
   // counted, not a delay range: the lock time may exceed what a range can reach
   logic        lockPending;
   logic [31:0] lockWait;
   always_ff @(posedge mclk) begin
      if (reset) begin
         lockPending <= 1'b1;
         lockWait <= 32'h0000_0000;
      end else if (clkEn && lockPending) begin
         lockPending <= !pllStable;
         lockWait <= lockWait + 32'h0000_0001;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn |=> wb_ack_o)
      else $error("request not acknowledged");
   a_ack_one_pulse: assert property (wb_ack_o && clkEn |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_usb_needs_lock: assert property (usbClkOn |-> pllStable)
      else $error("usb clock before lock");
   a_pll_sys_lock: assert property (pllSysClkOn |-> usbClkOn && pllStable)
      else $error("pll system clock without running pll");
   a_rc_predivide: assert property (!fastUsesCrystal |-> pllPreDivide)
      else $error("rc source without divide path");
   a_taps_follow: assert property (wdtSlowCrystal == slowUsesCrystal
      && timeBaseSlowCrystal == slowUsesCrystal && timeBaseFastCrystal == fastUsesCrystal)
      else $error("timer taps differ from selects");
   a_unlocked_at_release: assert property ($fell(reset) |-> !pllStable)
      else $error("pll stable right after reset");
   a_lock_after_reset: assert property (lockPending |-> lockWait <= 32'(LOCK_MAX))
      else $error("pll did not lock after reset");
   a_relock_fast: assert property ($changed(fastUsesCrystal) |-> ##[0:1] !pllStable)
      else $error("lock kept over source change");
endmodule : pllcs_props

/* verif/test_pll_clock_select.sv */
// testbench: register and clock select checks for pllcs_top
`timescale 1ns/1ps
module test_pll_clock_select;
   localparam int LK = 8;
   logic        mclk = 0, reset = 1, cyc = 0, stb = 0, we = 0, ack, irq, usb, pon, pdiv, fx, sx, wdt, tbf, tbs, stab;
   logic        ce = 1;
   logic [3:0]  adr = 0, sel = 4'hF;
   logic [31:0] wdat = 0, rdat, dout;
   logic [1:0]  freq;
   logic [2:0]  ssel;
   logic [7:0]  pv, sv;
   int          fail_count = 0, tests_run = 0, seed = 32'h94BF;
   pllcs_top #(.LOCK_CYCLES(LK)) pllcs_top_inst (.mclk(mclk), .reset(reset), .clkEn(ce), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dout),
      .wb_ack_o(ack), .irq(irq), .usbClkOn(usb), .pllSysClkOn(pon), .pllSysFreq(freq), .pllPreDivide(pdiv),
      .fastUsesCrystal(fx), .slowUsesCrystal(sx), .sysClkSelect(ssel), .wdtSlowCrystal(wdt),
      .timeBaseFastCrystal(tbf), .timeBaseSlowCrystal(tbs), .pllStable(stab));
   always #2.5 mclk = ~mclk;
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // ****************
   // bus cycle
   // ****************
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
      int n;
      n = 0;
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= s;
      do @(posedge mclk); while (ack !== 1'b1 && n++ < 50);
      if (n >= 50) begin
         fail_count++;
         finish_test();
      end
      rdat = dout;
      cyc  <= 1'b0;
      stb  <= 1'b0;
      @(posedge mclk);
   endtask : bus
   task automatic check_state;
      logic on;
      on = pv[0] && pv[4] && pv[3:2] != 2'h3;
      bus(1'b0, pllcs_pkg::ADDR_PLL_CONTROL, 32'h0);
      chk("pll ctl", {26'h0, pv[5:2], pv[0], pv[0]}, rdat);
      bus(1'b0, pllcs_pkg::ADDR_SYS_CLOCK_CONTROL, 32'h0);
      chk("clk ctl", {27'h0, sv[4:0]}, rdat);
      chk("usb", pv[0], usb);
      chk("pll sys", on, pon);
      if (on) chk("freq", pv[3:2], freq);
      chk("prediv", !(sv[0] && pv[5]), pdiv);
      chk("fast", sv[0], fx);
      chk("slow", sv[1], sx);
      chk("taps", {sv[1], sv[0], sv[1]}, {wdt, tbf, tbs});
      chk("sel", sv[4:2], ssel);
   endtask : check_state
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test
   initial begin
      #200000;
      fail_count++;
      finish_test();
   end
   initial begin
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      repeat (LK + 3) @(posedge mclk);
      chk("stable", 1'b1, stab);
      bus(1'b0, pllcs_pkg::ADDR_PLL_CONTROL, 32'h0);
      chk("pll ctl reset", 32'h3, rdat);
      chk("irq masked", 1'b0, irq);
      bus(1'b1, pllcs_pkg::ADDR_IRQ_MASK, 32'h3);
      chk("irq on", 1'b1, irq);
      bus(1'b0, pllcs_pkg::ADDR_IRQ_STATUS, 32'h0);
      chk("status", 32'h1, rdat);
      chk("irq clear", 1'b0, irq);
      bus(1'b1, pllcs_pkg::ADDR_IRQ_MASK, 32'h0);
      bus(1'b1, pllcs_pkg::ADDR_IRQ_MASK, 32'h3, 4'hE);
      bus(1'b0, pllcs_pkg::ADDR_IRQ_MASK, 32'h0);
      chk("mask sel0 off", 32'h0, rdat);
      bus(1'b1, 4'h1, 32'hFF);
      bus(1'b0, 4'h1, 32'h0);
      chk("unmapped", 32'h0, rdat);
      $display("test reset_irq done");
      // clock enable low must hold the lock counter where it stands
      bus(1'b1, pllcs_pkg::ADDR_SYS_CLOCK_CONTROL, 32'h1);
      ce <= 1'b0;
      repeat (LK + 3) @(posedge mclk);
      chk("frozen", 1'b0, stab);
      ce <= 1'b1;
      repeat (LK + 3) @(posedge mclk);
      chk("relocked", 1'b1, stab);
      chk("fast xtal", 1'b1, fx);
      $display("test clock_enable done");
      // every output code once with the pll off, once with it on
      for (int i = 0; i < 16; i++) begin
         pv = 8'($random(seed));
         sv = 8'($random(seed));
         pv[4:2] = i[2:0];
         pv[0] = i[3];
         bus(1'b1, pllcs_pkg::ADDR_PLL_CONTROL, {24'h0, pv});
         bus(1'b1, pllcs_pkg::ADDR_SYS_CLOCK_CONTROL, {24'h0, sv});
         repeat (LK + 3) @(posedge mclk);
         check_state();
      end
      bus(1'b0, pllcs_pkg::ADDR_IRQ_STATUS, 32'h0);
      chk("status sweep", 32'h3, rdat);
      $display("test select_sweep done");
      finish_test();
   end
endmodule : test_pll_clock_select
bind pllcs_top pllcs_props #(.LOCK_CYCLES(LOCK_CYCLES)) pllcs_props_inst (.mclk(mclk), .reset(reset),
   .clkEn(clkEn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .usbClkOn(usbClkOn), .pllSysClkOn(pllSysClkOn), .pllPreDivide(pllPreDivide),
   .fastUsesCrystal(fastUsesCrystal), .slowUsesCrystal(slowUsesCrystal), .wdtSlowCrystal(wdtSlowCrystal),
   .timeBaseFastCrystal(timeBaseFastCrystal), .timeBaseSlowCrystal(timeBaseSlowCrystal), .pllStable(pllStable));
